// *** rtl/trace_count_pkg.sv ***
// constants and carrier types for the trace count and comparator c page block
// assumes a 32-bit classic wishbone slave port with register index = byte address / 4
package trace_count_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h20;
  localparam logic [5:0] IDX_COUNT = 6'h24;
  localparam logic [5:0] IDX_PAGE_EXT = 6'h25;
  localparam logic [5:0] IDX_COMPARE_C = 6'h26;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h31;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h32;

  // first_debug_control fields
  localparam int CTRL_ARM_BIT = 7;
  localparam int CTRL_BEGIN_BIT = 4;
  localparam int CTRL_BREAK_BIT = 3;
  localparam int CTRL_CMPC_EN_BIT = 0;

  // trace_word_count fields
  localparam int COUNT_FULL_BIT = 7;
  localparam int COUNT_FIELD_BITS = 6;

  // compare_c_page_extension fields
  localparam int PAGE_PAGED_BIT = 6;
  localparam int EXT_BITS = 6;

  // interrupt event bits
  localparam int IRQ_BITS = 3;
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_MATCH_BIT = 2;

  localparam logic [1:0] BYTE_ALIGNED = 2'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_HALF = 16'h0000;

  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  // core address bus sample for comparator c
  typedef struct packed {
    logic valid;
    logic [7:0] programPage;
    logic [15:0] addr;
  } core_addr_type;

endpackage : trace_count_pkg

// *** rtl/trace_count_page_compare.sv ***
// trace word counter, full flag, session arm and comparator c with page extension
// assumes traceWrite and the core address bus come from logic on clk, so no synchronisers
// Behaviour
// - full flag set after 64 stored words; then all 64 entries count as valid
// - writing one to the arm bit clears the full flag
// - six-bit count field gives 0..63 valid words while full is clear
// - count wrap to zero sets full; end-trigger mode keeps counting
// - writing one to the arm bit clears full flag and count together
// - full at count zero in begin mode clears arm, breaks if enabled
// - full with nonzero count means oldest entries overwritten, all valid
// - page type field bits 7:6; bit 7 ignored
// - page type 01 compares extension to page bits; 00 uses plain 64k
// - comparator c works in breakpoint-only mode, governed by page type
// - trigger-position bit one selects begin storage, zero end storage
// - each low address bit compared to its comparator c value bit
`timescale 1ns/100ps
`default_nettype none
module trace_count_page_compare import trace_count_pkg::*; #(
  parameter int COUNT_BITS = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire wb_req_type wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  input wire logic traceWrite,
  input wire core_addr_type coreAddr,
  output logic sessionArmed,
  output logic breakRequest,
  output logic compareCMatch,
  output logic irq
);

  // the count must fit the six-bit field and address a real buffer
  if (COUNT_BITS < 1 || COUNT_BITS > COUNT_FIELD_BITS) begin : g_bad_count
    $error("COUNT_BITS must be 1 to 6");
  end

  logic [COUNT_BITS-1:0] countValue;
  logic traceFull;
  logic beginMode;
  logic breakEnable;
  logic compareCEnable;
  logic [7:0] pageExt;
  logic [15:0] compareC;
  logic [IRQ_BITS-1:0] irqStatus;
  logic [IRQ_BITS-1:0] irqEnable;
  logic [IRQ_BITS-1:0] next_irqStatus;
  logic [IRQ_BITS-1:0] next_irqEnable;
  logic [31:0] next_readData;

  logic busHit;
  logic [5:0] regIndex;
  logic writeStrobe;
  logic controlWrite;
  logic armWrite;
  logic storeWord;
  logic wrapNow;
  logic beginDone;
  logic pagedMode;
  logic [7:0] highTarget;
  logic extMatch;
  logic matchNow;

  // bus decode; misaligned accesses are acked but neither write nor read
  assign busHit = wbReq.cyc & wbReq.stb & ~wbAck;
  assign regIndex = wbReq.adr[7:2];
  // a write lands on the ack edge, while the master still holds the request
  assign writeStrobe = wbReq.cyc & wbReq.stb & wbAck & wbReq.we & (wbReq.adr[1:0] == BYTE_ALIGNED);
  assign controlWrite = writeStrobe & wbReq.sel[0] & (regIndex == IDX_CONTROL);
  assign armWrite = controlWrite & wbReq.dat[CTRL_ARM_BIT];

  // a word counts only while a session is armed
  assign storeWord = traceWrite & sessionArmed;
  assign wrapNow = storeWord & (countValue == {COUNT_BITS{1'b1}});
  assign beginDone = wrapNow & beginMode;

  // page type: only bit 6 matters, so 10/11 act as 00/01
  assign pagedMode = pageExt[PAGE_PAGED_BIT];
  // paged: program page supplies address bits 21:14
  assign highTarget = pagedMode ? {coreAddr.programPage[1:0], coreAddr.addr[13:8]} : coreAddr.addr[15:8];
  assign extMatch = ~pagedMode | (pageExt[EXT_BITS-1:0] == coreAddr.programPage[7:2]);
  // not gated by arm, so it also serves breakpoint-only use
  assign matchNow = coreAddr.valid & compareCEnable & extMatch & (compareC[15:8] == highTarget)
                    & (compareC[7:0] == coreAddr.addr[7:0]);

  // count and full flag; arm write wins so a new session starts empty
  always_ff @(posedge clk) begin
    if (rst || armWrite) begin
      countValue <= '0;
      traceFull <= 1'b0;
    end else if (storeWord) begin
      countValue <= COUNT_BITS'(countValue + 1'b1);
      if (wrapNow) begin
        traceFull <= 1'b1;
      end
    end
  end

  // session arm: software write sets or clears, begin-mode completion clears
  always_ff @(posedge clk) begin
    if (rst) begin
      sessionArmed <= 1'b0;
    end else if (controlWrite) begin
      sessionArmed <= wbReq.dat[CTRL_ARM_BIT];
    end else if (beginDone) begin
      sessionArmed <= 1'b0;
    end
  end

  // remaining control bits
  always_ff @(posedge clk) begin
    if (rst) begin
      beginMode <= 1'b0;
      breakEnable <= 1'b0;
      compareCEnable <= 1'b0;
    end else if (controlWrite) begin
      beginMode <= wbReq.dat[CTRL_BEGIN_BIT];
      breakEnable <= wbReq.dat[CTRL_BREAK_BIT];
      compareCEnable <= wbReq.dat[CTRL_CMPC_EN_BIT];
    end
  end

  // one-cycle break request at begin-mode completion
  always_ff @(posedge clk) begin
    if (rst) begin
      breakRequest <= 1'b0;
    end else begin
      breakRequest <= beginDone & breakEnable;
    end
  end

  // page extension and comparator c value, per byte lane
  always_ff @(posedge clk) begin
    if (rst) begin
      pageExt <= RESET_BYTE;
      compareC <= RESET_HALF;
    end else begin
      if (writeStrobe && wbReq.sel[0] && regIndex == IDX_PAGE_EXT) begin
        pageExt <= wbReq.dat[7:0]; // upper ext bits stored as written
      end
      if (writeStrobe && wbReq.sel[0] && regIndex == IDX_COMPARE_C) begin
        compareC[7:0] <= wbReq.dat[7:0];
      end
      if (writeStrobe && wbReq.sel[1] && regIndex == IDX_COMPARE_C) begin
        compareC[15:8] <= wbReq.dat[15:8];
      end
    end
  end

  // registered match so the output comes from a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      compareCMatch <= 1'b0;
    end else begin
      compareCMatch <= matchNow;
    end
  end

  // sticky status: an event in the clear cycle survives
  always_comb begin
    next_irqStatus = irqStatus;
    if (writeStrobe && wbReq.sel[0] && regIndex == IDX_IRQ_CLEAR) begin
      next_irqStatus = irqStatus & ~wbReq.dat[IRQ_BITS-1:0];
    end
    next_irqStatus[IRQ_FULL_BIT] = next_irqStatus[IRQ_FULL_BIT] | wrapNow;
    next_irqStatus[IRQ_DONE_BIT] = next_irqStatus[IRQ_DONE_BIT] | beginDone;
    next_irqStatus[IRQ_MATCH_BIT] = next_irqStatus[IRQ_MATCH_BIT] | matchNow;
  end

  // enable as it stands after this edge, so irq follows an enable write at once
  always_comb begin
    next_irqEnable = irqEnable;
    if (writeStrobe && wbReq.sel[0] && regIndex == IDX_IRQ_ENABLE) begin
      next_irqEnable = wbReq.dat[IRQ_BITS-1:0];
    end
  end

  // interrupt status, enable and level output
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= '0;
      irqEnable <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
      irq <= |(next_irqStatus & next_irqEnable);
    end
  end

  // read mux; unmapped or misaligned reads give zero
  always_comb begin
    next_readData = READ_ZERO;
    if (wbReq.adr[1:0] == BYTE_ALIGNED) begin
      unique case (regIndex)
        IDX_CONTROL: begin
          next_readData[CTRL_ARM_BIT] = sessionArmed;
          next_readData[CTRL_BEGIN_BIT] = beginMode;
          next_readData[CTRL_BREAK_BIT] = breakEnable;
          next_readData[CTRL_CMPC_EN_BIT] = compareCEnable;
        end
        IDX_COUNT: begin
          next_readData[COUNT_FULL_BIT] = traceFull;
          next_readData[COUNT_FIELD_BITS-1:0] = COUNT_FIELD_BITS'(countValue);
        end
        IDX_PAGE_EXT: next_readData[7:0] = pageExt;
        IDX_COMPARE_C: next_readData[15:0] = compareC;
        IDX_IRQ_STATUS: next_readData[IRQ_BITS-1:0] = irqStatus;
        IDX_IRQ_ENABLE: next_readData[IRQ_BITS-1:0] = irqEnable;
        default: next_readData = READ_ZERO;
      endcase
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatOut <= READ_ZERO;
    end else begin
      wbAck <= busHit;
      if (busHit && !wbReq.we) begin
        wbDatOut <= next_readData;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_arm_clears_count: assert property (armWrite |=> countValue == '0 && !traceFull)
    else $error("arm write did not clear count register");
  a_arm_clears_full: assert property (traceFull && armWrite |=> !traceFull)
    else $error("full flag survived arm write");
  a_full_on_wrap: assert property (wrapNow && !armWrite |=> traceFull && countValue == '0)
    else $error("wrap did not set full with count zero");
  a_full_sticky: assert property (traceFull && !armWrite |=> traceFull)
    else $error("full flag dropped without arm");
  a_count_step: assert property (storeWord && !armWrite |=> countValue == COUNT_BITS'($past(countValue) + 1'b1))
    else $error("count did not rise by one");
  a_count_hold: assert property (!storeWord && !armWrite |=> $stable(countValue))
    else $error("count changed without a stored word");
  a_begin_disarm: assert property (beginDone && !controlWrite
    |=> !sessionArmed ##1 (!sessionArmed || $past(controlWrite)))
    else $error("begin-mode completion left session armed");
  a_begin_break: assert property (beginDone && breakEnable |=> breakRequest ##1 !breakRequest)
    else $error("break request not a single pulse");
  a_end_continues: assert property (wrapNow && !beginMode && !controlWrite |=> sessionArmed)
    else $error("end-trigger mode stopped at wrap");
  a_flat_match: assert property (coreAddr.valid && compareCEnable && !pagedMode && compareC == coreAddr.addr
    |=> compareCMatch)
    else $error("flat compare missed");
  a_page_mismatch: assert property (pagedMode && pageExt[EXT_BITS-1:0] != coreAddr.programPage[7:2]
    |=> !compareCMatch)
    else $error("paged compare matched wrong page");
  a_count_read: assert property (busHit && !wbReq.we && wbReq.adr == {IDX_COUNT, BYTE_ALIGNED} && !traceWrite
    |=> wbAck && wbDatOut[COUNT_FULL_BIT] == traceFull)
    else $error("count register read wrong full flag");
  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");

  // session, counter and break
  a_idle_ignored: assert property (traceWrite && !sessionArmed && !armWrite |=> $stable(countValue) && $stable(traceFull))
    else $error("word counted while not armed");
  a_begin_full: assert property (beginDone |=> traceFull && countValue == '0)
    else $error("begin completion without full at count zero");
  a_break_only_done: assert property (!(beginDone && breakEnable) |=> !breakRequest)
    else $error("break request without begin completion");
  a_arm_follows: assert property (controlWrite |=> sessionArmed == $past(wbReq.dat[CTRL_ARM_BIT]))
    else $error("arm bit did not follow control write");

  // comparator c
  a_flat_high: assert property (coreAddr.valid && compareCEnable && !pagedMode
    && compareC[15:8] != coreAddr.addr[15:8] |=> !compareCMatch)
    else $error("flat compare matched wrong high byte");
  a_paged_match: assert property (coreAddr.valid && compareCEnable && pagedMode
    && pageExt[EXT_BITS-1:0] == coreAddr.programPage[7:2]
    && compareC == {coreAddr.programPage[1:0], coreAddr.addr[13:0]} |=> compareCMatch)
    else $error("paged compare missed");
  a_cmp_off: assert property (!compareCEnable |=> !compareCMatch)
    else $error("disabled comparator matched");
  a_low_mismatch: assert property (compareC[7:0] != coreAddr.addr[7:0] |=> !compareCMatch)
    else $error("low byte mismatch still matched");

  // interrupt and readback
  a_irq_level: assert property (irq == |(irqStatus & irqEnable))
    else $error("irq level disagrees with enabled status");
  a_wrap_status: assert property (wrapNow |=> irqStatus[IRQ_FULL_BIT])
    else $error("wrap did not set full status");
  a_status_sticky: assert property (irqStatus[IRQ_FULL_BIT] && !(writeStrobe && regIndex == IDX_IRQ_CLEAR)
    |=> irqStatus[IRQ_FULL_BIT])
    else $error("full status dropped without clear");
  a_count_field_read: assert property (busHit && !wbReq.we && wbReq.adr == {IDX_COUNT, BYTE_ALIGNED}
    |=> wbDatOut[COUNT_FIELD_BITS-1:0] == COUNT_FIELD_BITS'($past(countValue)))
    else $error("count field read back wrong");

  c_end_wrap: cover property (wrapNow && !beginMode ##[1:200] storeWord);
  c_begin_done: cover property (beginDone && breakEnable);
  c_paged_match: cover property (matchNow && pagedMode);
  c_irq_raised: cover property (!irq ##1 irq);
  c_arm_clear: cover property (armWrite && traceFull);

endmodule : trace_count_page_compare
`default_nettype wire

// *** test/core_bus_model.sv ***
// cpu core address and page source feeding comparator c
// assumes the bench asks for one sample at a time, on clk
`timescale 1ns/100ps
`default_nettype none
module core_bus_model import trace_count_pkg::*; (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] page,
  input wire logic [15:0] addr,
  output var core_addr_type coreAddr
);
  initial coreAddr = '0;
  // one valid sample per request; idle values toggle so nothing matches on stale bits
  always @(posedge clk) begin
    coreAddr.valid <= go;
    coreAddr.programPage <= go ? page : ~coreAddr.programPage; // page forms bits 21:14
    coreAddr.addr <= go ? addr : ~coreAddr.addr;
  end
endmodule : core_bus_model
`default_nettype wire

// *** test/trace_count_page_compare_tb.sv ***
// self-checking bench for the trace counter and comparator c page block
// assumes COUNT_BITS of 3, so the counter wraps after 8 stored words
`timescale 1ns/100ps
`default_nettype none
module trace_count_page_compare_tb import trace_count_pkg::*; ;
  localparam int CB = 3;
  localparam int DEPTH = 1 << CB;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic traceWrite = 1'b0;
  logic go = 1'b0;
  logic [7:0] page = 8'h00;
  logic [15:0] addr = 16'h0000;
  wb_req_type wbReq = '0;
  logic wbAck, sessionArmed, breakRequest, compareCMatch, irq;
  logic [31:0] wbDatOut, rd;
  core_addr_type coreAddr;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int brkSeen = 0;
  always #4 clk = ~clk;
  trace_count_page_compare #(.COUNT_BITS(CB)) uut (.clk(clk), .rst(rst), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatOut(wbDatOut), .traceWrite(traceWrite), .coreAddr(coreAddr),
    .sessionArmed(sessionArmed), .breakRequest(breakRequest), .compareCMatch(compareCMatch), .irq(irq));
  core_bus_model model (.clk(clk), .go(go), .page(page), .addr(addr), .coreAddr(coreAddr));
  // break pulse counter and hang guard; the whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (breakRequest === 1'b1) brkSeen <= brkSeen + 1;
    if (cycles == 4000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // classic single cycle; no latency assumed, only the guard ends a wait
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do @(posedge clk); while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbReq <= '0;
  endtask : wb
  // back-to-back stored words
  task automatic store(input int n);
    repeat (n) begin
      @(posedge clk);
      traceWrite <= 1'b1;
    end
    @(posedge clk);
    traceWrite <= 1'b0;
  endtask : store
  // model drives one sample, design answers the cycle after it samples
  task automatic probe(input logic [7:0] p, input logic [15:0] a, input logic exp);
    @(posedge clk);
    page <= p;
    addr <= a;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    chk("compare match", {31'h0, compareCMatch}, {31'h0, exp});
  endtask : probe
  task automatic t_reset();
    wb(1'b0, 8'h90, 32'h0);
    chk("count at reset", rd, 32'h0);
    wb(1'b1, 8'h90, 32'h0000_00ff);
    wb(1'b0, 8'h90, 32'h0);
    chk("count read only", rd, 32'h0);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped read", rd, 32'h0);
    store(3);
    wb(1'b0, 8'h90, 32'h0);
    chk("store while idle", rd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_end();
    wb(1'b1, 8'hc8, 32'h1);
    wb(1'b1, 8'h80, 32'h80); // arm in end-trigger storage
    store(DEPTH - 1);
    wb(1'b0, 8'h90, 32'h0);
    chk("count below full", rd, 32'(DEPTH - 1));
    chk("irq before wrap", {31'h0, irq}, 32'h0);
    store(1);
    wb(1'b0, 8'h90, 32'h0);
    chk("wrap sets full", rd, 32'h80);
    store(2);
    wb(1'b0, 8'h90, 32'h0);
    chk("end mode keeps counting", rd, 32'h82);
    chk("armed after wrap", {31'h0, sessionArmed}, 32'h1);
    chk("irq on wrap", {31'h0, irq}, 32'h1);
    wb(1'b0, 8'hc0, 32'h0);
    chk("status on wrap", rd, 32'h1);
    wb(1'b1, 8'hc4, 32'h1);
    wb(1'b1, 8'h80, 32'h80);
    wb(1'b0, 8'h90, 32'h0);
    chk("arm clears register", rd, 32'h0);
    chk("irq after clear", {31'h0, irq}, 32'h0);
    wb(1'b1, 8'h80, 32'h0);
    $display("test end mode done");
  endtask : t_end
  task automatic t_begin();
    int b0;
    b0 = brkSeen;
    wb(1'b1, 8'hc8, 32'h2);
    wb(1'b1, 8'h80, 32'h98); // begin storage with break enabled
    store(DEPTH);
    repeat (2) @(posedge clk);
    chk("one break", 32'(brkSeen - b0), 32'h1);
    chk("arm cleared", {31'h0, sessionArmed}, 32'h0);
    chk("irq on done", {31'h0, irq}, 32'h1);
    store(2);
    wb(1'b0, 8'h90, 32'h0);
    chk("stopped at full", rd, 32'h80);
    wb(1'b0, 8'hc0, 32'h0);
    chk("both events", rd, 32'h3);
    wb(1'b1, 8'hc8, 32'h0);
    repeat (2) @(posedge clk);
    chk("masked irq", {31'h0, irq}, 32'h0);
    wb(1'b1, 8'hc4, 32'h3);
    wb(1'b0, 8'hc0, 32'h0);
    chk("status cleared", rd, 32'h0);
    $display("test begin mode done");
  endtask : t_begin
  task automatic t_compare();
    wb(1'b1, 8'h98, 32'h1234);
    wb(1'b1, 8'h94, 32'h0);
    probe(8'h00, 16'h1234, 1'b0); // comparator still off
    wb(1'b1, 8'h80, 32'h1); // breakpoint-only, session idle
    probe(8'h00, 16'h1234, 1'b1);
    probe(8'h00, 16'h1235, 1'b0);
    probe(8'h00, 16'h9234, 1'b0);
    wb(1'b1, 8'h98, 32'h9234);
    wb(1'b1, 8'h94, 32'h45); // paged, upper extension bits zero
    probe(8'h16, 16'h1234, 1'b1);
    probe(8'h1a, 16'h1234, 1'b0);
    probe(8'h15, 16'h1234, 1'b0);
    wb(1'b1, 8'h94, 32'hc5);
    probe(8'h16, 16'h1234, 1'b1);
    wb(1'b1, 8'h94, 32'h85);
    probe(8'h16, 16'h1234, 1'b0);
    probe(8'h00, 16'h9234, 1'b1);
    wb(1'b0, 8'h94, 32'h0);
    chk("page ext readback", rd, 32'h85);
    $display("test compare done");
  endtask : t_compare
  // reset in mid-session: count and arm must both come back clear, so no later word is stored
  task automatic t_midreset();
    wb(1'b1, 8'h80, 32'h80); // arm in end-trigger storage
    store(3);
    wb(1'b0, 8'h80, 32'h0);
    chk("control readback", rd, 32'h80);
    wb(1'b0, 8'h90, 32'h0);
    chk("count before reset", rd, 32'h3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h90, 32'h0);
    chk("count after reset", rd, 32'h0);
    chk("disarmed by reset", {31'h0, sessionArmed}, 32'h0);
    store(2);
    wb(1'b0, 8'h90, 32'h0);
    chk("no store after reset", rd, 32'h0);
    $display("test mid reset done");
  endtask : t_midreset
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_end();
    t_begin();
    t_midreset();
    t_compare();
    report_and_stop();
  end
endmodule : trace_count_page_compare_tb
`default_nettype wire
